// file: pkg/rplc_pkg.sv
// Package of constants and types for the rotor positioning and lifter command handler
package rplc_pkg;
	// ==================================================
	// Command codes
	typedef enum logic [2:0] {
		RPLC_CMD_SETPOS,
		RPLC_CMD_POS,
		RPLC_CMD_RAISE,
		RPLC_CMD_LOWER,
		RPLC_CMD_RCYCLE,
		RPLC_CMD_BCYCLE,
		RPLC_CMD_CLOSE
	} rplc_cmd_e;
	// ==================================================
	// Reply status codes
	localparam logic [1:0] RPLC_ST_OK = 2'h0;
	localparam logic [1:0] RPLC_ST_ERR_LID = 2'h1;
	localparam logic [1:0] RPLC_ST_ERR_SPIN = 2'h2;
	localparam logic [1:0] RPLC_ST_ERR_CMD = 2'h3;
	// ==================================================
	// Widths, reset values, counter limit and unlock position
	localparam int RPLC_POS_W = 8;
	localparam int RPLC_CNT_W = 32;
	localparam logic [31:0] RPLC_CNT_RST = 32'h0000_0000;
	localparam logic [31:0] RPLC_CNT_MAX = 32'hFFFF_FFFF;
	localparam logic [7:0] RPLC_POS_UNLOCK = 8'h00;
endpackage : rplc_pkg

// file: core/rplc_core.sv
// Command handler for rotor positioning, bucket lifter and cycle counters
`timescale 1ns/1ps
module rplc_core (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Unit options
	input wire logic has_hatch,
	input wire logic has_lifter,
	input wire logic has_bucket_cnt,
	// Decoded command from the serial front end
	input wire logic cmd_valid,
	input wire rplc_pkg::rplc_cmd_e cmd_code,
	input wire logic [7:0] cmd_arg,
	output logic cmd_ready,
	// Reply to the serial front end
	output logic rsp_valid,
	output logic [1:0] rsp_status,
	output logic [31:0] rsp_data,
	// Mechanism status
	input wire logic lid_closed,
	input wire logic run_active,
	input wire logic rotor_spinning,
	input wire logic run_cycle_done,
	input wire logic lifter_at_bottom,
	input wire logic rotor_at_target,
	input wire logic [7:0] rotor_index,
	input wire logic [31:0] bucket_count,
	// Mechanism requests
	output logic run_stop,
	output logic lock_release,
	output logic rotor_move,
	output logic [7:0] rotor_target,
	output logic hatch_open,
	output logic lid_close,
	output logic lifter_up,
	output logic lifter_down,
	output logic pos_mode
);
	// ==================================================
	// Positioning sequencer states
	typedef enum logic [2:0] {
		RPLC_IDLE,
		RPLC_STOP,
		RPLC_LOWER,
		RPLC_MOVE
	} rplc_state_e;

	rplc_state_e state;
	rplc_state_e next_state;
	logic [7:0] target;
	logic [7:0] next_target;
	logic [31:0] rcount;
	logic [31:0] next_rcount;
	logic next_rsp_valid;
	logic [1:0] next_rsp_status;
	logic [31:0] next_rsp_data;
	logic next_lock_release;
	logic next_lifter_up;
	logic next_lifter_down;
	logic next_lid_close;
	logic next_pos_mode;
	logic busy;

	assign busy = (state != RPLC_IDLE);
	assign cmd_ready = !busy;

	// ==================================================
	// Command decode, positioning sequencer and counters
	always_comb begin
		next_state = state;
		next_target = target;
		next_rcount = rcount;
		next_rsp_valid = 1'b0;
		next_rsp_status = rsp_status;
		next_rsp_data = rsp_data;
		next_lock_release = 1'b0;
		next_lifter_up = 1'b0;
		next_lifter_down = 1'b0;
		next_lid_close = 1'b0;
		next_pos_mode = pos_mode;
		// Counter counts each finished run seen while clk_en is high and wraps naturally
		if (run_cycle_done) begin
			next_rcount = rcount + 32'h0000_0001;
		end
		unique case (state)
			RPLC_IDLE: begin
				if (cmd_valid) begin
					next_rsp_valid = 1'b1;
					next_rsp_status = rplc_pkg::RPLC_ST_OK;
					next_rsp_data = 32'h0000_0000;
					unique case (cmd_code)
						rplc_pkg::RPLC_CMD_SETPOS: begin
							if (!lid_closed) begin
								next_rsp_status = rplc_pkg::RPLC_ST_ERR_LID;
							end else if (cmd_arg == rplc_pkg::RPLC_POS_UNLOCK) begin
								next_lock_release = 1'b1;
							end else begin
								next_target = cmd_arg;
								next_pos_mode = 1'b1;
								next_rsp_valid = 1'b0;
								next_state = run_active ? RPLC_STOP : RPLC_LOWER;
								// One lowering pulse on entry, a held request would restart the travel
								next_lifter_down = has_lifter && !run_active;
							end
						end
						rplc_pkg::RPLC_CMD_POS: begin
							if (pos_mode) begin
								next_rsp_data = {24'h00_0000, rotor_index};
							end else begin
								next_rsp_status = rplc_pkg::RPLC_ST_ERR_CMD;
							end
						end
						rplc_pkg::RPLC_CMD_RAISE: begin
							if (rotor_spinning || run_active) begin
								next_rsp_status = rplc_pkg::RPLC_ST_ERR_SPIN;
							end else begin
								next_lifter_up = 1'b1;
							end
						end
						rplc_pkg::RPLC_CMD_LOWER: next_lifter_down = 1'b1;
						rplc_pkg::RPLC_CMD_RCYCLE: next_rsp_data = rcount;
						rplc_pkg::RPLC_CMD_BCYCLE: begin
							if (has_bucket_cnt) begin
								next_rsp_data = bucket_count;
							end else begin
								next_rsp_status = rplc_pkg::RPLC_ST_ERR_CMD;
							end
						end
						rplc_pkg::RPLC_CMD_CLOSE: next_lid_close = 1'b1;
						default: next_rsp_status = rplc_pkg::RPLC_ST_ERR_CMD;
					endcase
				end
			end
			RPLC_STOP: begin
				// Wait for the run to wind down before lowering
				if (!run_active) begin
					next_state = RPLC_LOWER;
					next_lifter_down = has_lifter;
				end
			end
			RPLC_LOWER: begin
				if (!has_lifter || lifter_at_bottom) begin
					next_state = RPLC_MOVE;
				end
			end
			RPLC_MOVE: begin
				if (rotor_at_target) begin
					next_state = RPLC_IDLE;
					next_rsp_valid = 1'b1;
					next_rsp_status = rplc_pkg::RPLC_ST_OK;
					next_rsp_data = {24'h00_0000, rotor_index};
				end
			end
			default: next_state = RPLC_IDLE;
		endcase
	end

	// Register all state
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= RPLC_IDLE;
			target <= 8'h00;
			rcount <= rplc_pkg::RPLC_CNT_RST;
			rsp_valid <= 1'b0;
			rsp_status <= 2'h0;
			rsp_data <= 32'h0000_0000;
			lock_release <= 1'b0;
			lifter_up <= 1'b0;
			lifter_down <= 1'b0;
			lid_close <= 1'b0;
			pos_mode <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			target <= next_target;
			rcount <= next_rcount;
			rsp_valid <= next_rsp_valid;
			rsp_status <= next_rsp_status;
			rsp_data <= next_rsp_data;
			lock_release <= next_lock_release;
			lifter_up <= next_lifter_up;
			lifter_down <= next_lifter_down;
			lid_close <= next_lid_close;
			pos_mode <= next_pos_mode;
		end
	end

	// Mechanism requests derived from sequencer state
	assign run_stop = (state == RPLC_STOP);
	assign rotor_move = (state == RPLC_MOVE);
	assign rotor_target = target;
	assign hatch_open = has_hatch && busy;

	// ==================================================
	// Assertions
	sequence s_pos_req;
		clk_en && cmd_valid && cmd_ready && cmd_code == rplc_pkg::RPLC_CMD_SETPOS && lid_closed && cmd_arg != 8'h00;
	endsequence

	property p_unlock;
		@(posedge mclk) disable iff (sys_rst)
		clk_en && cmd_valid && cmd_ready && cmd_code == rplc_pkg::RPLC_CMD_SETPOS && lid_closed && cmd_arg == 8'h00
		|=> lock_release && !rotor_move;
	endproperty
	a_unlock: assert property (p_unlock) else $error("unlock not issued");

	property p_target;
		@(posedge mclk) disable iff (sys_rst)
		s_pos_req |=> rotor_target == $past(cmd_arg) && busy;
	endproperty
	a_target: assert property (p_target) else $error("target not latched");

	property p_lid;
		@(posedge mclk) disable iff (sys_rst)
		clk_en && cmd_valid && cmd_ready && cmd_code == rplc_pkg::RPLC_CMD_SETPOS && !lid_closed
		|=> rsp_valid && rsp_status == rplc_pkg::RPLC_ST_ERR_LID && !busy;
	endproperty
	a_lid: assert property (p_lid) else $error("lid interlock missed");

	property p_stop;
		@(posedge mclk) disable iff (sys_rst)
		s_pos_req and run_active |=> run_stop;
	endproperty
	a_stop: assert property (p_stop) else $error("run not stopped");

	property p_hatch;
		@(posedge mclk) disable iff (sys_rst)
		rotor_move && has_hatch |-> hatch_open;
	endproperty
	a_hatch: assert property (p_hatch) else $error("hatch closed while moving");

	property p_lower_first;
		@(posedge mclk) disable iff (sys_rst)
		$rose(rotor_move) && has_lifter |-> $past(lifter_at_bottom);
	endproperty
	a_lower_first: assert property (p_lower_first) else $error("moved before bucket low");

	property p_raise_block;
		@(posedge mclk) disable iff (sys_rst)
		clk_en && cmd_valid && cmd_ready && cmd_code == rplc_pkg::RPLC_CMD_RAISE && rotor_spinning
		|=> !lifter_up && rsp_status == rplc_pkg::RPLC_ST_ERR_SPIN;
	endproperty
	a_raise_block: assert property (p_raise_block) else $error("raise while spinning");

	property p_count;
		@(posedge mclk) disable iff (sys_rst)
		clk_en && run_cycle_done |=> rcount == $past(rcount) + 32'h0000_0001;
	endproperty
	a_count: assert property (p_count) else $error("counter step wrong");

	property p_rcycle;
		@(posedge mclk) disable iff (sys_rst)
		clk_en && !run_cycle_done && cmd_valid && cmd_ready && cmd_code == rplc_pkg::RPLC_CMD_RCYCLE
		|=> rsp_valid && rsp_data == rcount;
	endproperty
	a_rcycle: assert property (p_rcycle) else $error("counter reply wrong");
endmodule : rplc_core

// file: sim/rplc_mech.sv
// Behavioural model of the run, lifter and rotor mechanism
`timescale 1ns/1ps
module rplc_mech (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// Bench control
	input wire logic run_go,
	// Requests from the handler
	input wire logic run_stop,
	input wire logic rotor_move,
	input wire logic [7:0] rotor_target,
	input wire logic lifter_up,
	input wire logic lifter_down,
	// Mechanism status
	output logic run_active,
	output logic rotor_spinning,
	output logic lifter_at_bottom,
	output logic rotor_at_target,
	output logic [7:0] rotor_index
);
	logic [2:0] lift_cnt;
	logic [2:0] move_cnt;
	// Rotor turns while a run or a move is on
	assign rotor_spinning = run_active | rotor_move;
	// Short travel times so the handler has to wait
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			run_active <= 1'b0;
			lifter_at_bottom <= 1'b0;
			lift_cnt <= 3'h0;
			move_cnt <= 3'h0;
			rotor_at_target <= 1'b0;
			rotor_index <= 8'h00;
		end else begin
			if (run_go)
				run_active <= 1'b1;
			else if (run_stop)
				run_active <= 1'b0;
			if (lifter_up) begin
				lifter_at_bottom <= 1'b0;
				lift_cnt <= 3'h0;
			end else if (lifter_down)
				lift_cnt <= 3'h1;
			else if (lift_cnt != 3'h0)
				lift_cnt <= lift_cnt + 3'h1;
			if (lift_cnt == 3'h3)
				lifter_at_bottom <= 1'b1;
			// Target flag drops as soon as the move request goes away
			if (!rotor_move) begin
				move_cnt <= 3'h0;
				rotor_at_target <= 1'b0;
			end else if (move_cnt == 3'h4) begin
				rotor_at_target <= 1'b1;
				rotor_index <= rotor_target;
			end else
				move_cnt <= move_cnt + 3'h1;
		end
	end
endmodule : rplc_mech

// file: sim/testbench.sv
// Self-checking testbench of the command handler
`timescale 1ns/1ps
module testbench;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic clk_en = 1'b1;
	logic run_go = 1'b0;
	logic lid_closed = 1'b0;
	logic has_bcnt = 1'b0;
	logic run_cycle_done = 1'b0;
	logic cmd_valid = 1'b0;
	rplc_pkg::rplc_cmd_e cmd_code = rplc_pkg::RPLC_CMD_POS;
	logic [7:0] cmd_arg = 8'h00;
	logic cmd_ready, rsp_valid, run_stop, lock_release, rotor_move, hatch_open;
	logic lid_close, lifter_up, lifter_down, pos_mode, run_active, spin, bottom, at_tgt;
	logic [1:0] rsp_status;
	logic [31:0] rsp_data;
	logic [7:0] rotor_target, rotor_index;
	logic [6:0] seen = 7'h00;
	int errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	// ==================================================
	// Clock, timeout and motion monitor
	always #2 mclk = ~mclk;
	always @(posedge mclk) begin
		seen <= seen | {rotor_move, lid_close, lifter_down, lifter_up, lock_release, hatch_open, run_stop};
		cycles++;
		if (cycles == 5000) begin
			errors++;
			stop_test();
		end
	end
	rplc_core uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .has_hatch(1'b1), .has_lifter(1'b1),
		.has_bucket_cnt(has_bcnt), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_arg(cmd_arg),
		.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_data(rsp_data),
		.lid_closed(lid_closed), .run_active(run_active), .rotor_spinning(spin),
		.run_cycle_done(run_cycle_done), .lifter_at_bottom(bottom), .rotor_at_target(at_tgt),
		.rotor_index(rotor_index), .bucket_count(32'hA5C3_0F12), .run_stop(run_stop),
		.lock_release(lock_release), .rotor_move(rotor_move), .rotor_target(rotor_target),
		.hatch_open(hatch_open), .lid_close(lid_close), .lifter_up(lifter_up),
		.lifter_down(lifter_down), .pos_mode(pos_mode));
	rplc_mech mech (.mclk(mclk), .sys_rst(sys_rst), .run_go(run_go), .run_stop(run_stop),
		.rotor_move(rotor_move), .rotor_target(rotor_target), .lifter_up(lifter_up),
		.lifter_down(lifter_down), .run_active(run_active), .rotor_spinning(spin),
		.lifter_at_bottom(bottom), .rotor_at_target(at_tgt), .rotor_index(rotor_index));
	// ==================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One command, then wait for its reply and let pulses settle
	task automatic send(input rplc_pkg::rplc_cmd_e c, input logic [7:0] a, input logic [1:0] st);
		int n;
		n = 0;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_arg <= a;
		#1 seen = 7'h00;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		while (n < 100 && rsp_valid !== 1'b1) begin
			#1;
			if (rsp_valid !== 1'b1)
				@(posedge mclk);
			n++;
		end
		chk("status", {30'h0, st}, {30'h0, rsp_status});
		@(posedge mclk);
		#1;
	endtask : send
	task automatic stop_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	// ==================================================
	// Scenarios
	task automatic t_counter();
		repeat (3) begin
			@(posedge mclk) run_cycle_done <= 1'b1;
			@(posedge mclk) run_cycle_done <= 1'b0;
		end
		// A finished run seen while the enable is low must not count
		@(posedge mclk) clk_en <= 1'b0;
		@(posedge mclk) run_cycle_done <= 1'b1;
		@(posedge mclk) run_cycle_done <= 1'b0;
		@(posedge mclk) clk_en <= 1'b1;
		send(rplc_pkg::RPLC_CMD_RCYCLE, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("rcycle", 32'h0000_0003, rsp_data);
	endtask : t_counter
	task automatic t_refuse();
		send(rplc_pkg::RPLC_CMD_SETPOS, 8'h05, rplc_pkg::RPLC_ST_ERR_LID);
		chk("motion", 32'h0, {25'h0, seen});
		send(rplc_pkg::RPLC_CMD_POS, 8'h00, rplc_pkg::RPLC_ST_ERR_CMD);
		send(rplc_pkg::RPLC_CMD_BCYCLE, 8'h00, rplc_pkg::RPLC_ST_ERR_CMD);
	endtask : t_refuse
	task automatic t_setpos();
		lid_closed <= 1'b1;
		send(rplc_pkg::RPLC_CMD_SETPOS, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("unlock", 32'h04, {25'h0, seen});
		@(posedge mclk) run_go <= 1'b1;
		@(posedge mclk) run_go <= 1'b0;
		send(rplc_pkg::RPLC_CMD_RAISE, 8'h00, rplc_pkg::RPLC_ST_ERR_SPIN);
		send(rplc_pkg::RPLC_CMD_SETPOS, 8'h05, rplc_pkg::RPLC_ST_OK);
		chk("setpos", 32'h05, rsp_data);
		chk("moves", 32'h53, {25'h0, seen});
		send(rplc_pkg::RPLC_CMD_POS, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("pos", 32'h05, rsp_data);
	endtask : t_setpos
	task automatic t_lifter();
		send(rplc_pkg::RPLC_CMD_RAISE, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("raise", 32'h08, {25'h0, seen});
		send(rplc_pkg::RPLC_CMD_LOWER, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("lower", 32'h10, {25'h0, seen});
		send(rplc_pkg::RPLC_CMD_CLOSE, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("close", 32'h20, {25'h0, seen});
		has_bcnt <= 1'b1;
		send(rplc_pkg::RPLC_CMD_BCYCLE, 8'h00, rplc_pkg::RPLC_ST_OK);
		chk("bcycle", 32'hA5C3_0F12, rsp_data);
	endtask : t_lifter
	initial begin
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		t_counter();
		t_refuse();
		t_setpos();
		t_lifter();
		stop_test();
	end
endmodule : testbench
